// ==== hdl/driver_control_register_map.sv ====
// Register bank and half-bridge control of the multi-output load driver
`timescale 1ns/100ps
`default_nettype none
module driver_control_register_map (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sclk,
    input wire logic csn_b,
    input wire logic data_in,
    output logic data_out,
    output logic data_out_en,
    input wire logic pulse_input_first,
    input wire logic pulse_input_second,
    input wire logic [15:0] overcurrent_events,
    input wire logic [15:0] undercurrent_events,
    input wire logic [15:0] load_supply_events,
    input wire logic thermal_shutdown,
    input wire logic thermal_warning,
    input wire logic not_ready,
    output logic [5:0] bridge_upper_on,
    output logic [5:0] bridge_lower_on,
    output logic active_mode
);
    // Synchronised pins
    logic select_sync;
    logic select_prev;
    logic [1:0] pulse_sync;
    logic [47:0] event_sync;
    logic [2:0] flag_sync;

    // Registers
    logic [15:0] output_control_a;
    logic [15:0] output_control_b;
    logic [15:0] recovery_pwm_control;
    logic [15:0] highside_monitor_control;
    logic [15:0] error_mask_config;
    logic [15:0] overcurrent_status;
    logic [15:0] bridge_undercurrent_status;
    logic [15:0] load_supply_status;
    logic comm_error;
    logic chip_reset;

    // Frame decode
    logic [23:0] rx_word;
    logic [4:0] bit_count;
    logic frame_end;
    logic frame_ok;
    logic [1:0] frame_op;
    logic [5:0] frame_addr;
    logic [15:0] frame_data;
    logic [1:0] live_op;
    logic [5:0] live_addr;
    logic [7:0] live_cmd;
    logic [15:0] read_word;
    logic [7:0] global_status;
    logic error_flag;
    logic do_write;
    logic do_clear;

    // Drivers
    logic [11:0] driver_request;
    logic [11:0] driver_gated;
    logic [5:0] next_upper;
    logic [5:0] next_lower;

    // Select synchroniser; inverted so its reset level matches an idle pin
    level_sync #(.WIDTH(1)) select_sync_inst (
        .clk(mclk),
        .rst_b(rst_b),
        .async_in(~csn_b),
        .sync_out(select_sync)
    );

    // Pulse inputs, two flip-flops before the gating
    level_sync #(.WIDTH(2)) pulse_sync_inst (
        .clk(mclk),
        .rst_b(rst_b),
        .async_in({pulse_input_second, pulse_input_first}),
        .sync_out(pulse_sync)
    );

    // Diagnosis events and device flags
    level_sync #(.WIDTH(51)) input_sync_inst (
        .clk(mclk),
        .rst_b(rst_b),
        .async_in({load_supply_events, undercurrent_events, overcurrent_events,
            not_ready, thermal_warning, thermal_shutdown}),
        .sync_out({event_sync, flag_sync})
    );

    // Serial link on its own clock
    spi_frame_link link_inst (
        .sclk(sclk),
        .rst_b(rst_b),
        .csn_b(csn_b),
        .data_in(data_in),
        .error_flag(error_flag),
        .tx_status(global_status),
        .tx_data(read_word),
        .rx_word(rx_word),
        .bit_count(bit_count),
        .data_out(data_out),
        .data_out_en(data_out_en)
    );

    // Frame end is the synchronised end of select
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            select_prev <= 1'b0;
        end else begin
            select_prev <= select_sync;
        end
    end

    assign frame_end = select_prev & ~select_sync;
    assign frame_ok = frame_end && (bit_count == driver_regs_pkg::FRAME_LEN);
    // Link word is static once select is low
    assign frame_op = rx_word[driver_regs_pkg::OP_MSB:driver_regs_pkg::OP_LSB];
    assign frame_addr = rx_word[driver_regs_pkg::ADDR_MSB:driver_regs_pkg::ADDR_LSB];
    assign frame_data = rx_word[driver_regs_pkg::DATA_MSB:0];
    assign do_write = frame_ok && (frame_op == driver_regs_pkg::OP_WRITE);
    assign do_clear = frame_ok && (frame_op == driver_regs_pkg::OP_READ_CLEAR);

    // Command byte of this frame: after k edges it sits at bits k-1 down to k-8
    // Settled from the eighth edge, when the answer word starts to leave
    assign live_cmd = 8'(rx_word >> (bit_count - 5'd8));
    assign live_op = live_cmd[7:6];
    assign live_addr = live_cmd[5:0];

    // Communication error and chip reset flags
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            comm_error <= 1'b0;
            chip_reset <= 1'b1;
        end else if (frame_end) begin
            comm_error <= (bit_count != driver_regs_pkg::FRAME_LEN);
            if (frame_ok) begin
                chip_reset <= 1'b0;
            end
        end
    end

    // Output control A, standby clears all
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            output_control_a <= driver_regs_pkg::CONTROL_RESET;
        end else if (do_write && frame_addr == driver_regs_pkg::OUTPUT_CONTROL_A_OFS) begin
            if (!frame_data[driver_regs_pkg::ENABLE_BIT]) begin
                output_control_a <= driver_regs_pkg::CONTROL_RESET;
            end else begin
                // Reserved bits kept at zero regardless of host
                output_control_a <= frame_data & driver_regs_pkg::CONTROL_A_WRITE_MASK;
            end
        end
    end

    // Remaining control registers and mask register
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            output_control_b <= driver_regs_pkg::CONTROL_RESET;
            recovery_pwm_control <= driver_regs_pkg::CONTROL_RESET;
            highside_monitor_control <= driver_regs_pkg::CONTROL_RESET;
            error_mask_config <= driver_regs_pkg::MASK_RESET;
        end else if (do_write) begin
            unique case (frame_addr)
                driver_regs_pkg::OUTPUT_CONTROL_B_OFS: begin
                    output_control_b <= frame_data;
                end
                driver_regs_pkg::RECOVERY_PWM_CONTROL_OFS: begin
                    recovery_pwm_control <= frame_data;
                end
                driver_regs_pkg::HIGHSIDE_MONITOR_CONTROL_OFS: begin
                    highside_monitor_control <= frame_data;
                end
                driver_regs_pkg::ERROR_MASK_CONFIG_OFS: begin
                    error_mask_config <= frame_data;
                end
                default: begin
                    // Read-only or unmapped: no change
                end
            endcase
        end
    end

    // Sticky diagnosis bits; a new event wins over read-and-clear
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            overcurrent_status <= driver_regs_pkg::STATUS_RESET;
            bridge_undercurrent_status <= driver_regs_pkg::STATUS_RESET;
            load_supply_status <= driver_regs_pkg::STATUS_RESET;
        end else begin
            if (do_clear && frame_addr == driver_regs_pkg::OVERCURRENT_STATUS_OFS) begin
                overcurrent_status <= event_sync[15:0];
            end else begin
                overcurrent_status <= overcurrent_status | event_sync[15:0];
            end
            if (do_clear && frame_addr == driver_regs_pkg::BRIDGE_UNDERCURRENT_STATUS_OFS) begin
                bridge_undercurrent_status <= event_sync[31:16];
            end else begin
                bridge_undercurrent_status <= bridge_undercurrent_status | event_sync[31:16];
            end
            if (do_clear && frame_addr == driver_regs_pkg::LOAD_SUPPLY_STATUS_OFS) begin
                load_supply_status <= event_sync[47:32];
            end else begin
                load_supply_status <= load_supply_status | event_sync[47:32];
            end
        end
    end

    // Global status byte with maskable warning and open load
    always_comb begin
        global_status[0] = flag_sync[2];
        global_status[1] = (|bridge_undercurrent_status)
            & ~error_mask_config[driver_regs_pkg::MASK_OPEN_LOAD_BIT];
        global_status[2] = |{overcurrent_status, load_supply_status};
        global_status[3] = flag_sync[1] & ~error_mask_config[driver_regs_pkg::MASK_THERMAL_WARN_BIT];
        global_status[4] = flag_sync[0];
        global_status[5] = chip_reset;
        global_status[6] = comm_error;
        global_status[7] = |global_status[6:0];
    end

    assign error_flag = global_status[7];

    // Answer word selected by the address being received
    always_comb begin
        read_word = 16'h0000;
        if (live_op == driver_regs_pkg::OP_DEVICE_INFO) begin
            unique case (live_addr)
                driver_regs_pkg::INFO_HEADER_OFS: read_word = driver_regs_pkg::INFO_HEADER_VAL;
                driver_regs_pkg::INFO_VERSION_OFS: read_word = driver_regs_pkg::INFO_VERSION_VAL;
                driver_regs_pkg::INFO_PRODUCT_FIRST_OFS: read_word = driver_regs_pkg::INFO_PRODUCT_FIRST_VAL;
                driver_regs_pkg::INFO_PRODUCT_SECOND_OFS: read_word = driver_regs_pkg::INFO_PRODUCT_SECOND_VAL;
                driver_regs_pkg::FRAME_FORMAT_ID_OFS: read_word = driver_regs_pkg::FRAME_FORMAT_ID_VAL;
                default: read_word = 16'h0000;
            endcase
        end else begin
            unique case (live_addr)
                driver_regs_pkg::OUTPUT_CONTROL_A_OFS: read_word = output_control_a;
                driver_regs_pkg::OUTPUT_CONTROL_B_OFS: read_word = output_control_b;
                driver_regs_pkg::RECOVERY_PWM_CONTROL_OFS: read_word = recovery_pwm_control;
                driver_regs_pkg::HIGHSIDE_MONITOR_CONTROL_OFS: read_word = highside_monitor_control;
                driver_regs_pkg::OVERCURRENT_STATUS_OFS: read_word = overcurrent_status;
                driver_regs_pkg::BRIDGE_UNDERCURRENT_STATUS_OFS: read_word = bridge_undercurrent_status;
                driver_regs_pkg::LOAD_SUPPLY_STATUS_OFS: read_word = load_supply_status;
                driver_regs_pkg::ERROR_MASK_CONFIG_OFS: read_word = error_mask_config;
                default: read_word = 16'h0000;
            endcase
        end
    end

    // Per-driver request with pulse gating; index 2k+1 upper, 2k lower
    genvar drv;
    generate
        for (drv = 0; drv < 12; drv++) begin : g_driver
            assign driver_request[drv] = output_control_a[driver_regs_pkg::DRIVER_LSB + drv];
            assign driver_gated[drv] = driver_request[drv]
                & (~recovery_pwm_control[drv]
                | (highside_monitor_control[drv] ? pulse_sync[1] : pulse_sync[0]));
        end
    endgenerate

    // Interlock and break-before-make per bridge; bridge one is the top pair
    genvar br;
    generate
        for (br = 0; br < driver_regs_pkg::BRIDGE_COUNT; br++) begin : g_bridge
            assign next_upper[br] = driver_gated[11 - 2 * br]
                & ~driver_gated[10 - 2 * br] & ~bridge_lower_on[br];
            assign next_lower[br] = driver_gated[10 - 2 * br]
                & ~driver_gated[11 - 2 * br] & ~bridge_upper_on[br];
        end
    endgenerate

    // Driver stages and mode flag
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bridge_upper_on <= '0;
            bridge_lower_on <= '0;
            active_mode <= 1'b0;
        end else begin
            bridge_upper_on <= next_upper;
            bridge_lower_on <= next_lower;
            active_mode <= output_control_a[driver_regs_pkg::ENABLE_BIT];
        end
    end
endmodule : driver_control_register_map
`default_nettype wire

// ==== hdl/driver_regs_pkg.sv ====
// Constants shared by the load-driver register bank and its serial link
package driver_regs_pkg;
    // Frame layout
    localparam int FRAME_BITS = 24;
    localparam logic [4:0] FRAME_LEN = 5'd24;
    localparam logic [4:0] CMD_BITS = 5'd8;
    localparam int OP_MSB = 23;
    localparam int OP_LSB = 22;
    localparam int ADDR_MSB = 21;
    localparam int ADDR_LSB = 16;
    localparam int DATA_MSB = 15;

    // Operation codes
    typedef enum logic [1:0] {
        OP_WRITE = 2'b00,
        OP_READ = 2'b01,
        OP_READ_CLEAR = 2'b10,
        OP_DEVICE_INFO = 2'b11
    } op_code_t;

    // RAM space offsets
    localparam logic [5:0] OUTPUT_CONTROL_A_OFS = 6'h00;
    localparam logic [5:0] OUTPUT_CONTROL_B_OFS = 6'h01;
    localparam logic [5:0] RECOVERY_PWM_CONTROL_OFS = 6'h02;
    localparam logic [5:0] HIGHSIDE_MONITOR_CONTROL_OFS = 6'h03;
    localparam logic [5:0] OVERCURRENT_STATUS_OFS = 6'h10;
    localparam logic [5:0] BRIDGE_UNDERCURRENT_STATUS_OFS = 6'h11;
    localparam logic [5:0] LOAD_SUPPLY_STATUS_OFS = 6'h12;
    localparam logic [5:0] ERROR_MASK_CONFIG_OFS = 6'h3f;

    // Device-information space offsets
    localparam logic [5:0] INFO_HEADER_OFS = 6'h00;
    localparam logic [5:0] INFO_VERSION_OFS = 6'h01;
    localparam logic [5:0] INFO_PRODUCT_FIRST_OFS = 6'h02;
    localparam logic [5:0] INFO_PRODUCT_SECOND_OFS = 6'h03;
    localparam logic [5:0] FRAME_FORMAT_ID_OFS = 6'h3e;
    localparam logic [15:0] FRAME_FORMAT_ID_VAL = 16'h0200;

    // Identity words: arbitrary neutral values
    localparam logic [15:0] INFO_HEADER_VAL = 16'h1a00;
    localparam logic [15:0] INFO_VERSION_VAL = 16'h0100;
    localparam logic [15:0] INFO_PRODUCT_FIRST_VAL = 16'h1b00;
    localparam logic [15:0] INFO_PRODUCT_SECOND_VAL = 16'h1c00;

    // Output control A fields
    localparam int ENABLE_BIT = 0;
    localparam int DRIVER_LSB = 4;
    localparam int BRIDGE_COUNT = 6;
    localparam logic [15:0] CONTROL_A_WRITE_MASK = 16'hfff1;

    // Error mask config fields
    localparam int MASK_OPEN_LOAD_BIT = 0;
    localparam int MASK_THERMAL_WARN_BIT = 1;

    // Reset values
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
endpackage : driver_regs_pkg

// ==== hdl/level_sync.sv ====
// Two-flip-flop synchroniser for a group of levels
`timescale 1ns/100ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= '0;
            sync_out <= '0;
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule : level_sync
`default_nettype wire

// ==== hdl/spi_frame_link.sv ====
// Serial-clock side of the 24-bit frame link
`timescale 1ns/100ps
`default_nettype none
module spi_frame_link (
    input wire logic sclk,
    input wire logic rst_b,
    input wire logic csn_b,
    input wire logic data_in,
    input wire logic error_flag,
    input wire logic [7:0] tx_status,
    input wire logic [15:0] tx_data,
    output logic [23:0] rx_word,
    output logic [4:0] bit_count,
    output logic data_out,
    output logic data_out_en
);
    logic armed;
    logic shift_q;
    logic [7:0] status_hold;
    logic [23:0] tx_word;
    logic [4:0] tx_index;

    // Armed while deselected, dropped at first clock of a frame
    always_ff @(posedge sclk or posedge csn_b) begin
        if (csn_b) begin
            armed <= 1'b1;
        end else begin
            armed <= 1'b0;
        end
    end

    // Shift in on rising edge, count edges (saturating)
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_word <= '0;
            bit_count <= '0;
        end else begin
            rx_word <= {rx_word[22:0], data_in};
            if (armed) begin
                bit_count <= 5'd1;
            end else if (bit_count != 5'h1f) begin
                bit_count <= bit_count + 5'd1;
            end
        end
    end

    // Global status caught on the first rising edge
    always_ff @(posedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            status_hold <= '0;
        end else if (armed) begin
            status_hold <= tx_status;
        end
    end

    assign tx_word = {status_hold, tx_data};
    assign tx_index = 5'd23 - bit_count;

    // Next answer bit out on falling edge
    always_ff @(negedge sclk or negedge rst_b) begin
        if (!rst_b) begin
            shift_q <= 1'b0;
        end else if (bit_count < driver_regs_pkg::FRAME_LEN) begin
            shift_q <= tx_word[tx_index];
        end else begin
            shift_q <= 1'b0;
        end
    end

    // Before the first clock the pin shows the error flag
    assign data_out = armed ? error_flag : shift_q;
    assign data_out_en = ~csn_b;
endmodule : spi_frame_link
`default_nettype wire

// ==== dv/spi_host_model.sv ====
// Host-side serial master that sends framed commands to the driver
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    output logic sclk,
    output logic csn_b,
    output logic data_in,
    input wire logic data_out
);
    // Idle: clock low, frame not selected
    initial begin
        sclk = 1'b0;
        csn_b = 1'b1;
        data_in = 1'b0;
    end

    // One frame of n clock pulses, MSB first, answer sampled on rising edges
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        if (w[23:16] == 8'h00) begin
            w[3:1] = 3'b000;
        end
        r = 24'h000000;
        #13 csn_b = 1'b0;
        for (int k = 0; k < n; k++) begin
            data_in = w[23-k];
            // Answer bit taken just before the rising edge, while it stands
            #40 r = {r[22:0], data_out};
            sclk = 1'b1;
            #40 sclk = 1'b0;
        end
        #40 csn_b = 1'b1;
        data_in = ~data_in; // Released line does not hold its value
        #400;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ==== dv/driver_control_register_map_checker.sv ====
// Port-level assertions for the load-driver register bank
`timescale 1ns/100ps
`default_nettype none
module driver_control_register_map_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic csn_b,
    input wire logic data_out_en,
    input wire logic [5:0] bridge_upper_on,
    input wire logic [5:0] bridge_lower_on,
    input wire logic active_mode
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // Any driver conducting
    wire logic any_on;
    assign any_on = (|bridge_upper_on) | (|bridge_lower_on);

    // Half-bridge interlock and break-before-make
    cross_guard_a: assert property ((bridge_upper_on & bridge_lower_on) == 6'h00)
        else $error("both drivers of one bridge on");
    upper_break_a: assert property ((bridge_upper_on & $past(bridge_lower_on)) == 6'h00)
        else $error("upper driver on right after lower");
    lower_break_a: assert property ((bridge_lower_on & $past(bridge_upper_on)) == 6'h00)
        else $error("lower driver on right after upper");
    // Standby switches everything off
    standby_off_a: assert property ($fell(active_mode) |-> ##[0:2] !any_on)
        else $error("drivers still on after standby");
    idle_off_a: assert property (!active_mode [*3] |-> !any_on)
        else $error("driver on in standby");
    // Mode changes only between frames
    mode_framed_a: assert property ($changed(active_mode) |-> csn_b)
        else $error("mode changed inside a frame");
    link_enable_a: assert property (data_out_en == !csn_b)
        else $error("answer enable not following select");
    reset_clear_a: assert property ($rose(rst_b) |-> !active_mode && !any_on)
        else $error("outputs not cleared by reset");

    // Main scenarios reached
    cover property ($rose(active_mode));
    cover property (|bridge_upper_on);
    cover property ($fell(csn_b));
endmodule : driver_control_register_map_checker
`default_nettype wire

// ==== dv/test_driver_control_register_map.sv ====
// Self-checking bench for the load-driver register bank
`timescale 1ns/100ps
`default_nettype none
module test_driver_control_register_map;
    logic mclk, rst_b, sclk, csn_b, data_in, data_out, data_out_en;
    logic pulse_input_first, pulse_input_second;
    logic [15:0] oc_ev;
    logic tw;
    logic [5:0] up, lo, eu, el;
    logic active_mode;
    logic [23:0] r;
    logic [15:0] prev;
    int n_fail, checked;

    // System clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    spi_host_model host (.sclk(sclk), .csn_b(csn_b), .data_in(data_in), .data_out(data_out));

    driver_control_register_map uut (
        .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .csn_b(csn_b), .data_in(data_in),
        .data_out(data_out), .data_out_en(data_out_en),
        .pulse_input_first(pulse_input_first), .pulse_input_second(pulse_input_second),
        .overcurrent_events(oc_ev), .undercurrent_events(16'h0000), .load_supply_events(16'h0000),
        .thermal_shutdown(1'b0), .thermal_warning(tw), .not_ready(1'b0),
        .bridge_upper_on(up), .bridge_lower_on(lo), .active_mode(active_mode)
    );

    // Word comparison
    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp16

    // Write; returns previous content in r
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        host.xfer({driver_regs_pkg::OP_WRITE, a, d}, 24, r);
    endtask : wr

    // Read with any opcode and compare the word
    task automatic rd(input logic [1:0] op, input logic [5:0] a, input logic [15:0] exp);
        host.xfer({op, a, 16'h0000}, 24, r);
        cmp16("read word", exp, r[15:0]);
    endtask : rd

    // Driver outputs and mode after settling
    task automatic drv(input logic [5:0] xu, input logic [5:0] xl, input logic xa);
        repeat (4) @(negedge mclk);
        cmp16("drivers", {3'b000, xa, xu, xl}, {3'b000, active_mode, up, lo});
    endtask : drv

    task automatic final_report;
        $display("counts: checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report

    // Hang guard
    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        final_report();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        pulse_input_first = 1'b0;
        pulse_input_second = 1'b0;
        oc_ev = 16'h0000;
        tw = 1'b0;
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(driver_regs_pkg::OP_DEVICE_INFO, driver_regs_pkg::FRAME_FORMAT_ID_OFS, 16'h0200);
        cmp16("status", 16'h00a0, {8'h00, r[23:16]});
        rd(driver_regs_pkg::OP_READ, 6'h3e, 16'h0000);
        $display("test info space done");
        // Read/write registers: reset value returned by first write
        for (int j = 0; j < 4; j++) begin
            eu = (j == 3) ? 6'h3f : 6'(j + 1);
            wr(eu, 16'h5a3c);
            cmp16("reset value", 16'h0000, r[15:0]);
            wr(eu, 16'h0000);
            cmp16("stored value", 16'h5a3c, r[15:0]);
        end
        wr(6'h10, 16'hffff);
        rd(driver_regs_pkg::OP_READ, 6'h10, 16'h0000);
        wr(6'h20, 16'hffff);
        rd(driver_regs_pkg::OP_READ, 6'h20, 16'h0000);
        $display("test map done");
        // Each driver bit alone, previous content checked on each write
        prev = 16'h0000;
        for (int i = 0; i < 12; i++) begin
            wr(6'h00, 16'h0001 | (16'h0010 << i));
            cmp16("previous content", prev, r[15:0]);
            prev = 16'h0001 | (16'h0010 << i);
            eu = 6'h00;
            el = 6'h00;
            if (i % 2 == 1) begin
                eu[5 - i / 2] = 1'b1;
            end else begin
                el[5 - i / 2] = 1'b1;
            end
            drv(eu, el, 1'b1);
        end
        wr(6'h00, 16'hc001);
        drv(6'h00, 6'h00, 1'b1);
        wr(6'h00, 16'h8001);
        drv(6'h01, 6'h00, 1'b1);
        $display("test drivers done");
        // Pulse gating on both inputs
        wr(6'h02, 16'h0800);
        drv(6'h00, 6'h00, 1'b1);
        @(posedge mclk);
        pulse_input_first <= 1'b1;
        drv(6'h01, 6'h00, 1'b1);
        wr(6'h03, 16'h0800);
        drv(6'h00, 6'h00, 1'b1);
        @(posedge mclk);
        pulse_input_second <= 1'b1;
        drv(6'h01, 6'h00, 1'b1);
        wr(6'h02, 16'h0000);
        $display("test pulse gating done");
        // Standby clears the whole register
        wr(6'h00, 16'h8000);
        drv(6'h00, 6'h00, 1'b0);
        rd(driver_regs_pkg::OP_READ, 6'h00, 16'h0000);
        $display("test standby done");
        // Sticky status and read-and-clear
        @(posedge mclk);
        oc_ev <= 16'h0008;
        repeat (4) @(posedge mclk);
        oc_ev <= 16'h0000;
        rd(driver_regs_pkg::OP_READ, 6'h10, 16'h0008);
        rd(driver_regs_pkg::OP_READ_CLEAR, 6'h10, 16'h0008);
        rd(driver_regs_pkg::OP_READ, 6'h10, 16'h0000);
        // Short frame ignored and flagged
        host.xfer(24'h008001, 23, r);
        rd(driver_regs_pkg::OP_READ, 6'h00, 16'h0000);
        cmp16("status", 16'h00c0, {8'h00, r[23:16]});
        $display("test status done");
        // Thermal warning reaches the status byte unless masked
        @(posedge mclk);
        tw <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(driver_regs_pkg::OP_READ, 6'h3f, 16'h0000);
        cmp16("status", 16'h0088, {8'h00, r[23:16]});
        wr(6'h3f, 16'h0002);
        rd(driver_regs_pkg::OP_READ, 6'h3f, 16'h0002);
        cmp16("status", 16'h0000, {8'h00, r[23:16]});
        $display("test mask done");
        final_report();
    end
endmodule : test_driver_control_register_map

bind driver_control_register_map driver_control_register_map_checker chk (
    .mclk(mclk), .rst_b(rst_b), .csn_b(csn_b), .data_out_en(data_out_en),
    .bridge_upper_on(bridge_upper_on), .bridge_lower_on(bridge_lower_on), .active_mode(active_mode)
);
`default_nettype wire
